// File: pkg/flash_ctl_pkg.sv
// constants and carrier types for the flash unlock/command controller
// assumes a register file bus with 12-bit address, 8-bit data and one-cycle strobes
// What this block does
// RULE_01 - unlock needs writes 73H then 8CH to the command port, in order
// RULE_02 - 95H as third write starts a page erase; elsewhere no erase
// RULE_03 - 63H as third write after unlock starts a mass erase
// RULE_04 - writing 5EH enables sector protect register write access
// RULE_05 - unknown value or misplaced valid value relocks the controller; writes during page or mass erase are ignored here instead
// RULE_06 - page erase touches only the page in the page selection register
// RULE_07 - mass erase honoured only for debugger accesses
// RULE_08 - mass erase stalls the core; clock and peripherals keep running
// RULE_09 - mass erase completion relocks; status shows it for polling
// RULE_10 - FF8H writes go to command port, reads return status
// RULE_11 - status readable anytime, state in bits 5..0, bits 7..6 zero
// RULE_12 - debugger accesses ignore the write-protect option bit
// RULE_13 - debugger accesses ignore sector protection for program and erase
// RULE_14 - debugger programming may leave the selected page
// RULE_15 - debugger may write sector protect bits to one or zero
// RULE_16 - debugger unlock needs no repeated page selection write
// RULE_17 - debugger may write page selection while unlocked
// RULE_18 - one page per unlock; another page needs a fresh unlock
// RULE_19 - trim bit index register at FF6H, 8 bits, reset 0, range 00H-1FH
// RULE_20 - page selection 80H maps the information page into program space
// RULE_21 - mass erase keeps the 32-byte lot identifier intact
// RULE_22 - bypass mode routes flash control signals to general purpose pins
// RULE_23 - only command port writes and erase completion move the lock machine; reads do not
package flash_ctl_pkg;
   localparam logic [11:0] trim_bit_target_index_addr = 12'h0FF6;
   localparam logic [11:0] flash_command_port_addr = 12'h0FF8;
   localparam logic [11:0] page_selection_register_addr = 12'h0FF9;
   localparam logic [11:0] sector_protect_addr = 12'h0FF9 + 12'h0001;
   localparam logic [7:0] cmd_unlock_first = 8'h73;
   localparam logic [7:0] cmd_unlock_second = 8'h8C;
   localparam logic [7:0] cmd_page_erase = 8'h95;
   localparam logic [7:0] cmd_mass_erase = 8'h63;
   localparam logic [7:0] cmd_sector_access = 8'h5E;
   localparam logic [7:0] info_page_select = 8'h80;
   localparam logic [7:0] trim_reset = 8'h00;
   localparam logic [7:0] trim_max = 8'h1F;
   localparam logic [7:0] page_reset = 8'h00;
   localparam logic [7:0] protect_reset = 8'h00;
   localparam int status_width = 6;
   localparam int page_bits = 7;
   localparam int lot_id_bytes = 32;

   typedef enum logic [5:0] {
      st_locked = 6'b00_0001,
      st_first = 6'b00_0010,
      st_unlocked = 6'b00_0100,
      st_page_erase = 6'b00_1000,
      st_mass_erase = 6'b01_0000,
      st_sector_open = 6'b10_0000
   } lock_state_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic debug;
      logic [11:0] addr;
      logic [7:0] wdata;
   } reg_req_type;

   typedef struct packed {
      logic erase_page;
      logic erase_mass;
      logic program_enable;
      logic [page_bits-1:0] page;
      logic info_page;
   } flash_ctl_type;
endpackage : flash_ctl_pkg

// File: verilog/flash_erase_timer.sv
// erase duration counter: pulses done after a programmable number of cycles
// assumes start is a one-cycle pulse from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module flash_erase_timer #(
   parameter int count_width = 16
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_enable,
   input wire logic i_start,
   input wire logic [count_width-1:0] i_length,
   output logic o_busy,
   output logic o_done
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [count_width-1:0] count;
   } timer_state_type;

   timer_state_type state;
   timer_state_type next_state;

   always_comb begin
      next_state = state;
      next_state.done = 1'b0;
      if (i_start && !state.busy) begin
         next_state.busy = 1'b1;
         next_state.count = i_length;
      end else if (state.busy) begin
         if (state.count <= count_width'(1)) begin
            next_state.busy = 1'b0;
            next_state.done = 1'b1;
         end else begin
            next_state.count = state.count - count_width'(1);
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= '0;
      end else if (i_enable) begin
         state <= next_state;
      end
   end

   assign o_busy = state.busy;
   assign o_done = state.done;
endmodule : flash_erase_timer
`default_nettype wire

// File: verilog/flash_unlock_command_controller.sv
// flash lock state machine, command/status port, trim index, page select, bypass routing
// assumes one register access per cycle on the register file bus; i_req.debug marks debugger accesses
`timescale 1ns/1ps
`default_nettype none
module flash_unlock_command_controller
   import flash_ctl_pkg::*;
#(
   parameter int erase_width = 16,
   parameter logic [erase_width-1:0] page_erase_cycles = 16'h0100,
   parameter logic [erase_width-1:0] mass_erase_cycles = 16'h1000
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_enable,
   input wire reg_req_type i_req,
   output logic [7:0] o_rdata,
   input wire logic i_write_protect,
   input wire logic i_bypass,
   input wire logic [page_bits-1:0] i_program_page,
   output flash_ctl_type o_flash,
   output logic o_flash_ctl_allowed,
   output logic o_cpu_stall,
   output logic [7:0] o_trim_index,
   output logic [7:0] o_sector_protect,
   output logic [4:0] o_lot_id_guard_bytes,
   output flash_ctl_type o_gpio_flash,
   output logic o_gpio_flash_oe_n,
   input wire logic i_gpio_erase_page,
   input wire logic i_gpio_program
);
   // all controller state except the erase timer in one record
   typedef struct packed {
      lock_state_type lock;
      logic [7:0] trim;
      logic [7:0] page;
      logic page_written;
      logic page_used;
      logic sector_open;
      logic [7:0] protect;
      logic [7:0] rdata;
      logic erase_start;
      logic erase_is_mass;
      logic bypass_s1;
      logic bypass_s2;
      logic gpio_erase_s1;
      logic gpio_erase_s2;
      logic gpio_prog_s1;
      logic gpio_prog_s2;
   } ctl_state_type;

   ctl_state_type state;
   ctl_state_type next_state;
   logic erase_busy;
   logic erase_done;
   logic wr_cmd;
   logic protected_page;
   logic [erase_width-1:0] erase_length;

   assign wr_cmd = i_req.wr && (i_req.addr == flash_command_port_addr); // RULE_10 RULE_23
   assign erase_length = state.erase_is_mass ? mass_erase_cycles : page_erase_cycles;

   flash_erase_timer #(
      .count_width(erase_width)
   ) u_timer (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_enable(i_enable),
      .i_start(state.erase_start),
      .i_length(erase_length),
      .o_busy(erase_busy),
      .o_done(erase_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // protection: sector bit for the selected page, waived for debugger
   always_comb begin
      protected_page = state.protect[state.page[page_bits-1:page_bits-3]];
      if (i_req.debug) begin
         protected_page = 1'b0; // RULE_13
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      next_state.erase_start = 1'b0;
      next_state.bypass_s1 = i_bypass;
      next_state.bypass_s2 = state.bypass_s1;
      next_state.gpio_erase_s1 = i_gpio_erase_page;
      next_state.gpio_erase_s2 = state.gpio_erase_s1;
      next_state.gpio_prog_s1 = i_gpio_program;
      next_state.gpio_prog_s2 = state.gpio_prog_s1;

      // read path, no side effect on lock machine
      next_state.rdata = 8'h00;
      if (i_req.rd) begin
         case (i_req.addr)
            flash_command_port_addr: next_state.rdata = {2'b00, state.lock}; // RULE_10 RULE_11 RULE_23
            trim_bit_target_index_addr: next_state.rdata = state.trim; // RULE_19
            page_selection_register_addr: next_state.rdata = state.page;
            sector_protect_addr: next_state.rdata = state.protect;
            default: next_state.rdata = 8'h00;
         endcase
      end

      if (i_req.wr && i_req.addr == trim_bit_target_index_addr) begin
         next_state.trim = (i_req.wdata > trim_max) ? trim_max : i_req.wdata; // RULE_19
      end

      // page selection: locked writes always, unlocked only from debugger
      if (i_req.wr && i_req.addr == page_selection_register_addr) begin
         if (state.lock == st_locked || state.lock == st_first || i_req.debug) begin // RULE_17
            next_state.page = i_req.wdata; // RULE_20
            next_state.page_written = 1'b1;
         end
      end

      // sector protect: normal mode only sets bits, debugger writes freely
      if (i_req.wr && i_req.addr == sector_protect_addr && state.sector_open) begin
         if (i_req.debug) begin
            next_state.protect = i_req.wdata; // RULE_15
         end else begin
            next_state.protect = state.protect | i_req.wdata;
         end
         next_state.sector_open = 1'b0;
      end

      if (wr_cmd) begin
         next_state.sector_open = 1'b0;
         case (state.lock)
            st_locked: begin
               if (i_req.wdata == cmd_unlock_first) begin
                  next_state.lock = st_first; // RULE_01
               end else if (i_req.wdata == cmd_sector_access) begin
                  next_state.sector_open = 1'b1; // RULE_04
               end else begin
                  next_state.lock = st_locked; // RULE_05
               end
            end
            st_first: begin
               // normal unlock needs a page selection write; debugger skips it
               if (i_req.wdata == cmd_unlock_second && (state.page_written || i_req.debug)) begin // RULE_16
                  next_state.lock = st_unlocked; // RULE_01
                  next_state.page_used = 1'b0;
               end else begin
                  next_state.lock = st_locked; // RULE_05
               end
            end
            st_unlocked: begin
               if (i_req.wdata == cmd_page_erase && !state.page_used && !protected_page
                  && (!i_write_protect || i_req.debug)) begin // RULE_12
                  next_state.lock = st_page_erase; // RULE_02
                  next_state.erase_start = 1'b1;
                  next_state.erase_is_mass = 1'b0;
                  next_state.page_used = 1'b1; // RULE_18
               end else if (i_req.wdata == cmd_mass_erase && i_req.debug) begin // RULE_07
                  next_state.lock = st_mass_erase; // RULE_03
                  next_state.erase_start = 1'b1;
                  next_state.erase_is_mass = 1'b1;
               end else if (i_req.wdata == cmd_sector_access) begin
                  next_state.sector_open = 1'b1; // RULE_04
               end else begin
                  next_state.lock = st_locked; // RULE_05
               end
            end
            st_page_erase, st_mass_erase: next_state.lock = state.lock;
            default: next_state.lock = st_locked;
         endcase
      end

      if (erase_done) begin
         if (state.lock == st_mass_erase) begin
            next_state.lock = st_locked; // RULE_09
         end else begin
            next_state.lock = st_unlocked;
         end
      end
      // clear only on entry to locked, so a page write made while locked survives
      if (next_state.lock == st_locked && state.lock != st_locked) begin
         next_state.page_written = 1'b0;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= '{lock: st_locked, trim: trim_reset, page: page_reset, protect: protect_reset, default: '0};
      end else if (i_enable) begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flash control outputs, with bypass routing
   flash_ctl_type internal_ctl;
   logic page_ok;

   always_comb begin
      page_ok = (i_program_page == state.page[page_bits-1:0]) || i_req.debug; // RULE_14
      internal_ctl.erase_page = (state.lock == st_page_erase) && erase_busy; // RULE_06
      internal_ctl.erase_mass = (state.lock == st_mass_erase) && erase_busy;
      internal_ctl.program_enable = (state.lock == st_unlocked) && page_ok && !protected_page
         && (!i_write_protect || i_req.debug); // RULE_12 RULE_18
      internal_ctl.page = state.page[page_bits-1:0]; // RULE_06
      internal_ctl.info_page = (state.page == info_page_select); // RULE_20
   end

   always_comb begin
      o_flash = internal_ctl;
      o_gpio_flash = '0;
      o_gpio_flash_oe_n = 1'b1;
      if (state.bypass_s2) begin
         o_flash = '0;
         o_flash.erase_page = state.gpio_erase_s2; // RULE_22
         o_flash.program_enable = state.gpio_prog_s2;
         o_flash.page = state.page[page_bits-1:0];
         o_gpio_flash = internal_ctl; // RULE_22
         o_gpio_flash_oe_n = 1'b0;
      end
   end

   assign o_flash_ctl_allowed = (state.lock == st_unlocked);
   assign o_cpu_stall = (state.lock == st_mass_erase); // RULE_08
   assign o_lot_id_guard_bytes = 5'(lot_id_bytes - 1); // RULE_21
   assign o_rdata = state.rdata;
   assign o_trim_index = state.trim;
   assign o_sector_protect = state.protect;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_unlock_pair;
      wr_cmd && i_req.wdata == cmd_unlock_first && state.lock == st_locked && i_enable
      ##[1:2] wr_cmd && i_req.wdata == cmd_unlock_second && i_enable && state.lock == st_first
      && (state.page_written || i_req.debug);
   endsequence

   a_unlock_pair_opens: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_01
      s_unlock_pair |=> state.lock == st_unlocked)
      else $error("unlock pair did not unlock");
   a_page_erase_start: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_02
      i_enable && wr_cmd && i_req.wdata == cmd_page_erase && state.lock != st_unlocked
      |=> state.lock != st_page_erase)
      else $error("page erase out of position");
   a_mass_erase_debug: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_07
      i_enable && wr_cmd && !i_req.debug && state.lock != st_mass_erase |=> state.lock != st_mass_erase)
      else $error("mass erase without debugger");
   a_bad_cmd_relocks: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_05
      i_enable && wr_cmd && state.lock == st_first && i_req.wdata != cmd_unlock_second |=> state.lock == st_locked)
      else $error("bad command did not relock");
   a_stall_mass: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_08
      o_cpu_stall == (state.lock == st_mass_erase))
      else $error("stall not tied to mass erase");
   a_mass_done_lock: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_09
      i_enable && erase_done && state.lock == st_mass_erase |=> state.lock == st_locked)
      else $error("mass erase end did not relock");
   a_status_upper_zero: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_11
      o_rdata[7:6] == 2'b00)
      else $error("status reserved bits set");
   a_read_no_move: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_23
      i_enable && !i_req.wr && !erase_done |=> $stable(state.lock))
      else $error("read moved lock state");
   a_trim_range: assert property (@(posedge i_clock) disable iff (!i_nrst) // RULE_19
      state.trim <= trim_max)
      else $error("trim index out of range");
endmodule : flash_unlock_command_controller
`default_nettype wire

// File: bench/flash_core_model.sv
// core/debugger model: issues register file writes and reads
// assumes requests are launched and released at the falling edge
`timescale 1ns/1ps
`default_nettype none
module flash_core_model
   import flash_ctl_pkg::*;
(
   input wire logic i_clock,
   input wire logic [7:0] i_rdata,
   output var reg_req_type o_req
);
   initial begin
      o_req = '0;
   end

   // released bus shows inverted stale address and data
   task automatic bus_idle();
      o_req.wr = 1'b0;
      o_req.rd = 1'b0;
      o_req.addr = ~o_req.addr;
      o_req.wdata = ~o_req.wdata;
   endtask : bus_idle

   // sequence order is the caller's duty
   task automatic bus_write(input logic [11:0] a, input logic [7:0] d, input logic dbg);
      @(negedge i_clock);
      o_req = '{wr: 1'b1, rd: 1'b0, debug: dbg, addr: a, wdata: d};
      @(negedge i_clock);
      bus_idle();
   endtask : bus_write

   task automatic bus_read(input logic [11:0] a, output logic [7:0] d);
      @(negedge i_clock);
      o_req.rd = 1'b1;
      o_req.debug = 1'b0;
      o_req.addr = a;
      @(negedge i_clock);
      d = i_rdata;
      bus_idle();
   endtask : bus_read
endmodule : flash_core_model
`default_nettype wire

// File: bench/flash_unlock_command_controller_tb.sv
// testbench for the flash unlock/command controller
// assumes short erase counts and the core model as requester
`timescale 1ns/1ps
`default_nettype none
module flash_unlock_command_controller_tb;
   import flash_ctl_pkg::*;
   logic i_clock;
   logic i_nrst;
   logic i_bypass;
   reg_req_type req;
   logic [7:0] rdata;
   flash_ctl_type flash;
   logic allowed;
   logic stall;
   logic [7:0] sector;
   logic oe_n;
   logic wp;
   logic [7:0] trim;
   logic [4:0] lot;
   flash_ctl_type gpio_flash;
   int miscompares = 0;
   int cmp_count = 0;

   flash_unlock_command_controller #(.erase_width(16), .page_erase_cycles(16'h0004),
      .mass_erase_cycles(16'h0004)) dut (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_enable(1'b1), .i_req(req), .o_rdata(rdata),
      .i_write_protect(wp), .i_bypass(i_bypass), .i_program_page(7'h00), .o_flash(flash),
      .o_flash_ctl_allowed(allowed), .o_cpu_stall(stall), .o_trim_index(trim), .o_sector_protect(sector),
      .o_lot_id_guard_bytes(lot), .o_gpio_flash(gpio_flash), .o_gpio_flash_oe_n(oe_n),
      .i_gpio_erase_page(1'b0), .i_gpio_program(1'b0));

   flash_core_model core (.i_clock(i_clock), .i_rdata(rdata), .o_req(req));

   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end

   ////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic reg_chk(input logic [11:0] a, input logic [7:0] exp);
      logic [7:0] d;
      core.bus_read(a, d);
      chk($sformatf("reg %h", a), exp, d);
   endtask : reg_chk

   task automatic wait_stat(input logic [7:0] exp);
      logic [7:0] d;
      for (int i = 0; i < 40; i++) begin
         core.bus_read(flash_command_port_addr, d);
         if (d === exp) begin
            break;
         end
      end
      chk("status wait", exp, d);
      if (d !== exp) begin
         wrap_up();
      end
   endtask : wait_stat

   task automatic cmd(input logic [7:0] d, input logic dbg);
      core.bus_write(flash_command_port_addr, d, dbg);
   endtask : cmd

   task automatic unlock(input logic dbg, input logic [7:0] page);
      if (!dbg) begin
         core.bus_write(page_selection_register_addr, page, 1'b0);
      end
      cmd(cmd_unlock_first, dbg);
      cmd(cmd_unlock_second, dbg);
   endtask : unlock

   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      reg_chk(flash_command_port_addr, 8'h01);
      reg_chk(trim_bit_target_index_addr, 8'h00);
      chk("allowed", 8'h00, {7'h00, allowed});
      $display("test reset done");
   endtask : t_reset

   task automatic t_page_erase();
      unlock(1'b0, 8'h05);
      reg_chk(flash_command_port_addr, 8'h04);
      chk("allowed", 8'h01, {7'h00, allowed});
      cmd(cmd_page_erase, 1'b0);
      reg_chk(flash_command_port_addr, 8'h08);
      chk("erase page", 8'h05, {1'b0, flash.page});
      chk("no mass", 8'h00, {7'h00, flash.erase_mass});
      wait_stat(8'h04);
      cmd(8'h00, 1'b0);
      $display("test page erase done");
   endtask : t_page_erase

   task automatic t_relock();
      reg_chk(flash_command_port_addr, 8'h01);
      cmd(cmd_unlock_first, 1'b0);
      reg_chk(flash_command_port_addr, 8'h02);
      reg_chk(flash_command_port_addr, 8'h02);
      cmd(8'h12, 1'b0);
      reg_chk(flash_command_port_addr, 8'h01);
      cmd(cmd_page_erase, 1'b0);
      reg_chk(flash_command_port_addr, 8'h01);
      cmd(cmd_unlock_second, 1'b0);
      reg_chk(flash_command_port_addr, 8'h01);
      $display("test relock done");
   endtask : t_relock

   task automatic t_protect();
      wp = 1'b1;
      unlock(1'b0, 8'h05);
      cmd(cmd_page_erase, 1'b0);
      reg_chk(flash_command_port_addr, 8'h01);
      unlock(1'b1, 8'h05);
      cmd(cmd_page_erase, 1'b1);
      reg_chk(flash_command_port_addr, 8'h08);
      wait_stat(8'h04);
      cmd(8'h00, 1'b1);
      wp = 1'b0;
      $display("test write protect done");
   endtask : t_protect

   task automatic t_mass();
      unlock(1'b0, 8'h01);
      cmd(cmd_mass_erase, 1'b0);
      chk("normal stall", 8'h00, {7'h00, stall});
      chk("normal mass", 8'h00, {7'h00, flash.erase_mass});
      cmd(8'h00, 1'b0);
      unlock(1'b1, 8'h00);
      reg_chk(flash_command_port_addr, 8'h04);
      cmd(cmd_mass_erase, 1'b1);
      chk("debug stall", 8'h01, {7'h00, stall});
      reg_chk(flash_command_port_addr, 8'h10);
      wait_stat(8'h01);
      chk("stall end", 8'h00, {7'h00, stall});
      $display("test mass erase done");
   endtask : t_mass

   task automatic t_trim();
      core.bus_write(trim_bit_target_index_addr, 8'h1F, 1'b0);
      reg_chk(trim_bit_target_index_addr, 8'h1F);
      core.bus_write(trim_bit_target_index_addr, 8'h25, 1'b0);
      reg_chk(trim_bit_target_index_addr, 8'h1F);
      chk("trim out", 8'h1F, trim);
      chk("lot guard", 8'h1F, {3'b000, lot});
      $display("test trim done");
   endtask : t_trim

   task automatic t_sector();
      unlock(1'b1, 8'h00);
      cmd(cmd_sector_access, 1'b1);
      core.bus_write(sector_protect_addr, 8'h55, 1'b1);
      chk("sector", 8'h55, sector);
      cmd(8'h00, 1'b1);
      $display("test sector done");
   endtask : t_sector

   task automatic t_info_bypass();
      core.bus_write(page_selection_register_addr, info_page_select, 1'b0);
      chk("info page", 8'h01, {7'h00, flash.info_page});
      core.bus_write(page_selection_register_addr, 8'h00, 1'b0);
      @(negedge i_clock);
      i_bypass = 1'b1;
      repeat (4) @(negedge i_clock);
      chk("gpio oe_n", 8'h00, {7'h00, oe_n});
      chk("gpio page", 8'h00, {1'b0, gpio_flash.page});
      i_bypass = 1'b0;
      $display("test info and bypass done");
   endtask : t_info_bypass

   initial begin
      i_nrst = 1'b0;
      i_bypass = 1'b0;
      wp = 1'b0;
      repeat (2) @(negedge i_clock);
      i_nrst = 1'b1;
      t_reset();
      t_page_erase();
      t_relock();
      t_protect();
      t_mass();
      t_trim();
      t_sector();
      t_info_bypass();
      wrap_up();
   end
endmodule : flash_unlock_command_controller_tb
`default_nettype wire
